// [hdl/mid_core.sv]
// Instruction decode and execute core with AXI4-Lite control registers
// Behaviour
// - Each instruction is one 14-bit word: opcode plus operand fields.
// - Instructions fall into byte, bit, and literal/control classes.
// - Byte operations pick their register through the register-select field.
// - Destination bit 0 writes the accumulator, 1 writes the register.
// - Register-select is seven bits, addresses 0x00 to 0x7F.
// - Bit operations act on one of eight bit positions.
// - Literal operand is 8 bits or 11 bits depending on instruction.
// - One instruction cycle lasts four clock periods.
// - Taken tests and program counter changes take two cycles, second idle.
// - Register operands are always read first; results are stored back only for destination 1 and bit set/clear.
// - The implicit read of the port register counts as a port read.
// - Don't-care opcode bits are ignored whatever their value.
// - Top opcode bits 00 mark byte-class register operations.
`timescale 1ns/10ps
module mid_core
  import mid_pkg::*;
#(
  parameter int             PC_W      = 13,
  parameter int             STACK_D   = 8,
  parameter logic [6:0]     PORT_ADDR = 7'h05
) (
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  // Program memory
  output logic [PC_W-1:0]        prog_addr_o,
  input  wire logic [INSTR_W-1:0] prog_data_i,
  // Data register file
  output logic [FILE_AW-1:0]     file_addr_o,
  output logic                   file_re_o,
  input  wire logic [7:0]        file_rdata_i,
  output logic                   file_we_o,
  output logic [7:0]             file_wdata_o,
  output logic                   port_rd_o,
  // Wake from sleep
  input  wire logic              wake_i,
  // AXI4-Lite slave
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [7:0]        s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp
);
  localparam int SP_W = $clog2(STACK_D);

  // Core state
  logic [1:0]         phase_r, phase_nxt;
  logic [13:0]        instr_r, instr_nxt;
  logic [PC_W-1:0]    program_counter_r, program_counter_nxt;
  logic [7:0]         w_r, w_nxt;
  logic [7:0]         fval_r, fval_nxt;
  logic [7:0]         res_r, res_nxt;
  logic               c_r, c_nxt, dc_r, dc_nxt, z_r, z_nxt;
  logic               dummy_r, dummy_nxt;
  logic               sleep_r, sleep_nxt;
  logic [SP_W-1:0]    sp_r, sp_nxt;
  logic [PC_W-1:0]    stack_r [STACK_D];
  logic [PC_W-1:0]    stack_nxt [STACK_D];
  logic               run_r, run_nxt;

  mid_class_t cls;
  mid_op_t    op;
  logic       uses_file, wr_file, wr_w;
  logic [7:0] alu_res;
  logic       alu_c, alu_dc, upd_c, upd_dc, upd_z;
  logic       active, commit, skip, branch, flush;

  mid_decode u_dec (
    .instr_i     (instr_r),
    .cls_o       (cls),
    .op_o        (op),
    .uses_file_o (uses_file),
    .wr_file_o   (wr_file),
    .wr_w_o      (wr_w)
  );

  mid_alu u_alu (
    .op_i     (op),
    .fval_i   (fval_r),
    .wval_i   (w_r),
    .lit_i    (instr_r[LIT8_W-1:0]),
    .bsel_i   (instr_r[9:7]),
    .c_i      (c_r),
    .res_o    (alu_res),
    .c_o      (alu_c),
    .dc_o     (alu_dc),
    .upd_c_o  (upd_c),
    .upd_dc_o (upd_dc),
    .upd_z_o  (upd_z)
  );

  always_comb begin
    active    = run_r && !sleep_r;
    commit    = active && phase_r == PHASE_LAST;
    skip      = ((op inside {OP_DECSZ, OP_INCSZ}) && res_r == 8'h00) ||
                (op == OP_BTSC && !fval_r[instr_r[9:7]]) ||
                (op == OP_BTSS && fval_r[instr_r[9:7]]);
    branch    = op inside {OP_CALL, OP_JUMP, OP_RETL, OP_RET, OP_RETI};
    flush     = skip || branch;
    file_addr_o  = instr_r[FILE_AW-1:0];
    file_re_o    = active && phase_r == 2'h0 && uses_file;
    port_rd_o    = file_re_o && file_addr_o == PORT_ADDR;
    file_we_o    = commit && wr_file;
    file_wdata_o = res_r;
    prog_addr_o  = program_counter_r;
  end

  always_comb begin
    phase_nxt           = phase_r + 2'h1;
    instr_nxt           = instr_r;
    program_counter_nxt = program_counter_r;
    w_nxt     = w_r;
    fval_nxt  = fval_r;
    res_nxt   = res_r;
    c_nxt     = c_r;
    dc_nxt    = dc_r;
    z_nxt     = z_r;
    dummy_nxt = dummy_r;
    sleep_nxt = sleep_r && !wake_i;
    sp_nxt    = sp_r;
    stack_nxt = stack_r;
    if (active && phase_r == 2'h1) begin
      fval_nxt = file_rdata_i;
    end
    if (active && phase_r == 2'h2) begin
      res_nxt = alu_res;
      if (upd_c) begin
        c_nxt = alu_c;
      end
      if (upd_dc) begin
        dc_nxt = alu_dc;
      end
    end
    if (commit) begin
      if (wr_w) begin
        w_nxt = res_r;
      end
      if (upd_z) begin
        z_nxt = res_r == 8'h00;
      end
      program_counter_nxt = program_counter_r + {{(PC_W-1){1'b0}}, 1'b1};
      case (op)
        OP_CALL: begin
          stack_nxt[sp_r] = program_counter_r;
          sp_nxt          = sp_r + {{(SP_W-1){1'b0}}, 1'b1};
          program_counter_nxt = {{(PC_W-LIT11_W){1'b0}}, instr_r[LIT11_W-1:0]};
        end
        OP_JUMP: begin
          program_counter_nxt = {{(PC_W-LIT11_W){1'b0}}, instr_r[LIT11_W-1:0]};
        end
        OP_RET, OP_RETL, OP_RETI: begin
          sp_nxt              = sp_r - {{(SP_W-1){1'b0}}, 1'b1};
          program_counter_nxt = stack_r[sp_nxt];
        end
        OP_SLEEP: begin
          sleep_nxt = !wake_i;
        end
        default: begin
        end
      endcase
      instr_nxt = flush ? NOP_WORD : prog_data_i;
      dummy_nxt = flush;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_r           <= 2'h0;
      instr_r           <= NOP_WORD;
      program_counter_r <= '0;
      w_r      <= 8'h00;
      fval_r   <= 8'h00;
      res_r    <= 8'h00;
      c_r      <= 1'b0;
      dc_r     <= 1'b0;
      z_r      <= 1'b0;
      dummy_r  <= 1'b1;
      sleep_r  <= 1'b0;
      sp_r     <= '0;
      stack_r  <= '{default: '0};
    end else begin
      phase_r           <= phase_nxt;
      instr_r           <= instr_nxt;
      program_counter_r <= program_counter_nxt;
      w_r      <= w_nxt;
      fval_r   <= fval_nxt;
      res_r    <= res_nxt;
      c_r      <= c_nxt;
      dc_r     <= dc_nxt;
      z_r      <= z_nxt;
      dummy_r  <= dummy_nxt;
      sleep_r  <= sleep_nxt;
      sp_r     <= sp_nxt;
      stack_r  <= stack_nxt;
    end
  end

  // AXI4-Lite slave: address and data taken in either order
  logic        aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [7:0]  awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic        wstrb0_r, wstrb0_nxt;
  logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        do_wr;

  always_comb begin
    s_axi_awready = !aw_hold_r && !bvalid_r;
    s_axi_wready  = !w_hold_r && !bvalid_r;
    s_axi_arready = !rvalid_r;
    aw_hold_nxt = aw_hold_r || (s_axi_awvalid && s_axi_awready);
    w_hold_nxt  = w_hold_r || (s_axi_wvalid && s_axi_wready);
    awaddr_nxt  = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : awaddr_r;
    wdata_nxt   = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wdata_r;
    wstrb0_nxt  = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb[0] : wstrb0_r;
    do_wr       = aw_hold_r && w_hold_r && !bvalid_r;
    run_nxt     = run_r;
    bvalid_nxt  = bvalid_r && !s_axi_bready;
    bresp_nxt   = bresp_r;
    if (do_wr) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = (awaddr_r inside {ADDR_CTRL, ADDR_STATUS, ADDR_WREG}) ? RESP_OKAY
                                                                         : RESP_SLVERR;
      if (awaddr_r == ADDR_CTRL && wstrb0_r) begin
        run_nxt = wdata_r[CTRL_RUN];
      end
    end
    rvalid_nxt = rvalid_r && !s_axi_rready;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL:   rdata_nxt = {31'h0, run_r};
        ADDR_STATUS: rdata_nxt = {11'h0, dummy_r, sleep_r, z_r, dc_r, c_r,
                                  {(16-PC_W){1'b0}}, program_counter_r};
        ADDR_WREG:   rdata_nxt = {24'h0, w_r};
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    s_axi_bvalid = bvalid_r;
    s_axi_bresp  = bresp_r;
    s_axi_rvalid = rvalid_r;
    s_axi_rdata  = rdata_r;
    s_axi_rresp  = rresp_r;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0;
      wstrb0_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= 32'h0;
      run_r     <= CTRL_RST;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb0_r  <= wstrb0_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
      run_r     <= run_nxt;
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  cycle_four_a: assert property (commit |=> !commit [*3] ##1 (commit || !active))
    else $error("instruction cycle is not four clocks");
  flush_idle_a: assert property (commit && flush |=> instr_r == NOP_WORD && dummy_r)
    else $error("taken skip or branch did not insert idle cycle");
  rmw_read_a: assert property (file_we_o |-> $past(file_re_o, 3))
    else $error("register written without prior read");
  port_read_a: assert property (port_rd_o |-> file_re_o && file_addr_o == PORT_ADDR)
    else $error("port read strobe without register read");
  dest_w_a: assert property (commit && cls == CL_BYTE && !instr_r[7] |-> !file_we_o)
    else $error("accumulator destination wrote the register");
  bit_set_a: assert property (commit && op == OP_BSET |-> file_wdata_o[instr_r[9:7]])
    else $error("selected bit not set");
  jump_target_a: assert property (commit && op == OP_JUMP
                                  |=> program_counter_r == $past(instr_r[10:0]))
    else $error("jump target is not the 11-bit literal");
  class_bit_a: assert property (instr_r[13:12] == 2'b01 |-> cls == CL_BIT)
    else $error("bit class misdecoded");
  byte_class_a: assert property (instr_r[13:12] == 2'b00 |-> cls == CL_BYTE)
    else $error("byte class misdecoded");

  skip_c: cover property (commit && skip);
  call_c: cover property (commit && op == OP_CALL);
  port_c: cover property (port_rd_o);
  sleep_c: cover property (commit && op == OP_SLEEP);
endmodule : mid_core

// [shared/mid_pkg.sv]
// Constants and types shared by the instruction decode core
package mid_pkg;
  localparam int          INSTR_W     = 14;
  localparam int          FILE_AW     = 7;
  localparam int          LIT8_W      = 8;
  localparam int          LIT11_W     = 11;
  localparam logic [1:0]  PHASE_LAST  = 2'h3;
  localparam logic [13:0] NOP_WORD    = 14'h0000;
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_WREG   = 8'h08;
  localparam int          CTRL_RUN    = 0;
  localparam logic        CTRL_RST    = 1'h0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {CL_BYTE, CL_BIT, CL_LIT} mid_class_t;

  typedef enum logic [5:0] {
    OP_NOP, OP_MOVWF, OP_CLRW, OP_CLRF, OP_SUBF, OP_DECF, OP_IORF, OP_ANDF,
    OP_XORF, OP_ADDF, OP_MOVF, OP_COMF, OP_INCF, OP_DECSZ, OP_RRF, OP_RLF,
    OP_SWAPF, OP_INCSZ, OP_BCLR, OP_BSET, OP_BTSC, OP_BTSS, OP_CALL, OP_JUMP,
    OP_MOVL, OP_RETL, OP_IORL, OP_ANDL, OP_XORL, OP_SUBL, OP_ADDL, OP_RET,
    OP_RETI, OP_SLEEP
  } mid_op_t;
endpackage : mid_pkg

// [hdl/mid_decode.sv]
// Instruction word decoder: class, operation and destination controls
`timescale 1ns/10ps
module mid_decode
  import mid_pkg::*;
(
  // Instruction
  input  wire logic [INSTR_W-1:0] instr_i,
  // Decoded controls
  output mid_class_t              cls_o,
  output mid_op_t                 op_o,
  output logic                    uses_file_o,
  output logic                    wr_file_o,
  output logic                    wr_w_o
);
  function automatic mid_op_t decode_op(input logic [13:0] iw);
    mid_op_t o;
    o = OP_NOP;
    casez (iw)
      14'b00_0000_1???_????: o = OP_MOVWF;
      14'b00_0000_0000_1000: o = OP_RET;
      14'b00_0000_0000_1001: o = OP_RETI;
      14'b00_0000_0110_0011: o = OP_SLEEP;
      14'b00_0001_0???_????: o = OP_CLRW;
      14'b00_0001_1???_????: o = OP_CLRF;
      14'b00_0010_????_????: o = OP_SUBF;
      14'b00_0011_????_????: o = OP_DECF;
      14'b00_0100_????_????: o = OP_IORF;
      14'b00_0101_????_????: o = OP_ANDF;
      14'b00_0110_????_????: o = OP_XORF;
      14'b00_0111_????_????: o = OP_ADDF;
      14'b00_1000_????_????: o = OP_MOVF;
      14'b00_1001_????_????: o = OP_COMF;
      14'b00_1010_????_????: o = OP_INCF;
      14'b00_1011_????_????: o = OP_DECSZ;
      14'b00_1100_????_????: o = OP_RRF;
      14'b00_1101_????_????: o = OP_RLF;
      14'b00_1110_????_????: o = OP_SWAPF;
      14'b00_1111_????_????: o = OP_INCSZ;
      14'b01_00??_????_????: o = OP_BCLR;
      14'b01_01??_????_????: o = OP_BSET;
      14'b01_10??_????_????: o = OP_BTSC;
      14'b01_11??_????_????: o = OP_BTSS;
      14'b10_0???_????_????: o = OP_CALL;
      14'b10_1???_????_????: o = OP_JUMP;
      14'b11_00??_????_????: o = OP_MOVL;
      14'b11_01??_????_????: o = OP_RETL;
      14'b11_1000_????_????: o = OP_IORL;
      14'b11_1001_????_????: o = OP_ANDL;
      14'b11_1010_????_????: o = OP_XORL;
      14'b11_110?_????_????: o = OP_SUBL;
      14'b11_111?_????_????: o = OP_ADDL;
      default:               o = OP_NOP;
    endcase
    return o;
  endfunction : decode_op

  always_comb begin
    op_o = decode_op(instr_i);
    case (instr_i[13:12])
      2'b00:   cls_o = CL_BYTE;
      2'b01:   cls_o = CL_BIT;
      default: cls_o = CL_LIT;
    endcase
    uses_file_o = (cls_o == CL_BIT) || (op_o inside {[OP_MOVWF:OP_INCSZ]} && op_o != OP_CLRW);
    wr_file_o   = (cls_o == CL_BIT) ? (op_o inside {OP_BCLR, OP_BSET})
                                    : (uses_file_o && instr_i[7]);
    wr_w_o      = (uses_file_o && cls_o == CL_BYTE && !instr_i[7]) ||
                  (op_o inside {OP_CLRW, [OP_MOVL:OP_ADDL]});
  end
endmodule : mid_decode

// [hdl/mid_alu.sv]
// Arithmetic and logic unit for byte, bit and literal operations
`timescale 1ns/10ps
module mid_alu
  import mid_pkg::*;
(
  // Operands
  input  mid_op_t    op_i,
  input  wire logic [7:0] fval_i,
  input  wire logic [7:0] wval_i,
  input  wire logic [7:0] lit_i,
  input  wire logic [2:0] bsel_i,
  input  wire logic       c_i,
  // Result and flags
  output logic [7:0] res_o,
  output logic       c_o,
  output logic       dc_o,
  output logic       upd_c_o,
  output logic       upd_dc_o,
  output logic       upd_z_o
);
  function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b,
                                      input logic ci);
    return {1'b0, a} + {1'b0, b} + {8'h00, ci};
  endfunction : add9

  function automatic logic nib_c(input logic [7:0] a, input logic [7:0] b, input logic ci);
    logic [4:0] s;
    s = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    return s[4];
  endfunction : nib_c

  logic [8:0] sum;
  logic [7:0] a_op;
  logic [7:0] b_op;
  logic       cin;
  logic [7:0] bmask;

  always_comb begin
    bmask = 8'h01 << bsel_i;
    a_op  = (op_i inside {OP_SUBL, OP_ADDL}) ? lit_i : fval_i;
    b_op  = (op_i inside {OP_SUBF, OP_SUBL}) ? ~wval_i : wval_i;
    cin   = op_i inside {OP_SUBF, OP_SUBL};
    sum   = add9(a_op, b_op, cin);
    res_o = fval_i;
    c_o   = sum[8];
    dc_o  = nib_c(a_op, b_op, cin);
    case (op_i)
      OP_MOVWF:                  res_o = wval_i;
      OP_CLRW, OP_CLRF:          res_o = 8'h00;
      OP_SUBF, OP_ADDF,
      OP_SUBL, OP_ADDL:          res_o = sum[7:0];
      OP_DECF, OP_DECSZ:         res_o = fval_i - 8'h01;
      OP_INCF, OP_INCSZ:         res_o = fval_i + 8'h01;
      OP_IORF:                   res_o = fval_i | wval_i;
      OP_ANDF:                   res_o = fval_i & wval_i;
      OP_XORF:                   res_o = fval_i ^ wval_i;
      OP_COMF:                   res_o = ~fval_i;
      OP_RRF: begin
        res_o = {c_i, fval_i[7:1]};
        c_o   = fval_i[0];
      end
      OP_RLF: begin
        res_o = {fval_i[6:0], c_i};
        c_o   = fval_i[7];
      end
      OP_SWAPF:                  res_o = {fval_i[3:0], fval_i[7:4]};
      OP_BCLR:                   res_o = fval_i & ~bmask;
      OP_BSET:                   res_o = fval_i | bmask;
      OP_MOVL, OP_RETL:          res_o = lit_i;
      OP_IORL:                   res_o = wval_i | lit_i;
      OP_ANDL:                   res_o = wval_i & lit_i;
      OP_XORL:                   res_o = wval_i ^ lit_i;
      default:                   res_o = fval_i;
    endcase
    upd_c_o  = op_i inside {OP_SUBF, OP_ADDF, OP_SUBL, OP_ADDL, OP_RRF, OP_RLF};
    upd_dc_o = op_i inside {OP_SUBF, OP_ADDF, OP_SUBL, OP_ADDL};
    upd_z_o  = op_i inside {OP_CLRW, OP_CLRF, OP_SUBF, OP_DECF, OP_IORF, OP_ANDF, OP_XORF,
                            OP_ADDF, OP_MOVF, OP_COMF, OP_INCF, [OP_IORL:OP_ADDL]};
  end
endmodule : mid_alu

// [tb/mid_mem_model.sv]
// Behavioural program memory and data register file facing the core
`timescale 1ns/10ps
module mid_mem_model
  import mid_pkg::*;
(
  // Clock
  input  wire logic               clk_i,
  // Program memory
  input  wire logic [12:0]        prog_addr_i,
  output logic [INSTR_W-1:0]      prog_data_o,
  // Register file
  input  wire logic [FILE_AW-1:0] file_addr_i,
  input  wire logic               file_re_i,
  output logic [7:0]              file_rdata_o,
  input  wire logic               file_we_i,
  input  wire logic [7:0]         file_wdata_i
);
  logic [INSTR_W-1:0] rom [0:8191];
  logic [7:0]         ram [0:127];

  initial begin
    foreach (rom[i]) rom[i] = '0;
    foreach (ram[i]) ram[i] = '0;
    file_rdata_o = 8'h00;
  end

  assign prog_data_o = rom[prog_addr_i];

  // Read data holds for one cycle after the strobe, then toggles so stale data is never seen
  always @(posedge clk_i) begin
    if (file_re_i) begin
      file_rdata_o <= ram[file_addr_i];
    end else begin
      file_rdata_o <= ~file_rdata_o;
    end
    if (file_we_i) begin
      ram[file_addr_i] <= file_wdata_i;
    end
  end
endmodule : mid_mem_model

// [tb/mid_core_test.sv]
// Self-checking testbench for the instruction decode core
`timescale 1ns/10ps
module mid_core_test
  import mid_pkg::*;
;
  logic              core_clk_i;
  logic              rst_n_i;
  logic [12:0]       prog_addr;
  logic [13:0]       prog_data;
  logic [6:0]        file_addr;
  logic              file_re;
  logic [7:0]        file_rdata;
  logic              file_we;
  logic [7:0]        file_wdata;
  logic              port_rd;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready;
  logic [7:0]        s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  int                error_cnt, cmp_count, cyc, port_cnt;
  int                we_cyc[$];

  mid_core dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .prog_addr_o(prog_addr),
    .prog_data_i(prog_data), .file_addr_o(file_addr), .file_re_o(file_re),
    .file_rdata_i(file_rdata), .file_we_o(file_we), .file_wdata_o(file_wdata),
    .port_rd_o(port_rd), .wake_i(1'b0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp));

  mid_mem_model mem_u (.clk_i(core_clk_i), .prog_addr_i(prog_addr), .prog_data_o(prog_data),
    .file_addr_i(file_addr), .file_re_i(file_re), .file_rdata_o(file_rdata),
    .file_we_i(file_we), .file_wdata_i(file_wdata));

  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  // Cycle count, timeout and strobe monitors
  always @(posedge core_clk_i) begin
    cyc++;
    if (file_we === 1'b1) we_cyc.push_back(cyc);
    if (port_rd === 1'b1) port_cnt++;
    if (cyc >= 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk_i);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk_i);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic test_regs();
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(ADDR_CTRL, d, r);
    cmp(d, 32'h0);
    cmp({30'h0, r}, {30'h0, RESP_OKAY});
    axi_rd(ADDR_STATUS, d, r);
    cmp(d, 32'h0010_0000);
    axi_rd(ADDR_WREG, d, r);
    cmp(d, 32'h0);
    axi_rd(8'h0c, d, r);
    cmp({d[29:0], r}, {30'h0, RESP_SLVERR});
    axi_wr(8'h0c, 32'h1, r);
    cmp({30'h0, r}, {30'h0, RESP_SLVERR});
  endtask : test_regs

  // Byte, bit, skip, port and literal operations, then a jump loop
  task automatic test_prog();
    logic [13:0] prog [11] = '{14'h303c, 14'h00a0, 14'h0720, 14'h0aa1, 14'h17a2, 14'h1fa2,
                               14'h00a3, 14'h0185, 14'h017f, 14'h087f, 14'h280a};
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    foreach (prog[i]) mem_u.rom[i] = prog[i];
    mem_u.ram[7'h05] = 8'h3c;
    mem_u.ram[7'h21] = 8'h0f;
    mem_u.ram[7'h23] = 8'h55;
    mem_u.ram[7'h7f] = 8'ha5;
    axi_wr(ADDR_CTRL, 32'h1, r);
    axi_rd(ADDR_CTRL, d, r);
    cmp(d, 32'h1);
    n = 0;
    while (prog_addr !== 13'd10 && n < 500) begin
      @(posedge core_clk_i);
      n++;
    end
    repeat (12) @(posedge core_clk_i);
    axi_rd(ADDR_WREG, d, r);
    cmp(d, 32'ha5);
    cmp({24'h0, mem_u.ram[7'h20]}, 32'h3c);
    cmp({24'h0, mem_u.ram[7'h21]}, 32'h10);
    cmp({24'h0, mem_u.ram[7'h22]}, 32'h80);
    cmp({24'h0, mem_u.ram[7'h23]}, 32'h55);
    cmp({24'h0, mem_u.ram[7'h05]}, 32'h00);
    cmp(port_cnt, 32'd1);
    cmp(we_cyc.size(), 32'd4);
    if (we_cyc.size() == 4) begin
      cmp(we_cyc[1] - we_cyc[0], 32'd8);
      cmp(we_cyc[2] - we_cyc[1], 32'd4);
      cmp(we_cyc[3] - we_cyc[2], 32'd12);
    end
    axi_rd(ADDR_STATUS, d, r);
    cmp({31'h0, d[12:0] <= 13'd11}, 32'h1);
    cmp({29'h0, d[18:16]}, 32'h2);
    axi_rd(ADDR_WREG, d, r);
    cmp(d, 32'ha5);
    cmp({24'h0, mem_u.ram[7'h7f]}, 32'ha5);
    axi_wr(ADDR_CTRL, 32'h0, r);
    axi_rd(ADDR_CTRL, d, r);
    cmp(d, 32'h0);
  endtask : test_prog

  // Reset with the core stopped, then a call and a literal return
  task automatic test_call();
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge core_clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    axi_rd(ADDR_STATUS, d, r);
    cmp(d, 32'h0010_0000);
    mem_u.rom[0] = 14'h2004;
    mem_u.rom[1] = 14'h00b0;
    mem_u.rom[2] = 14'h2802;
    mem_u.rom[4] = 14'h345a;
    axi_wr(ADDR_CTRL, 32'h1, r);
    repeat (60) @(posedge core_clk_i);
    axi_rd(ADDR_STATUS, d, r);
    cmp({31'h0, d[12:1] == 12'h001}, 32'h1);
    axi_rd(ADDR_WREG, d, r);
    cmp(d, 32'h5a);
    cmp({24'h0, mem_u.ram[7'h30]}, 32'h5a);
    axi_wr(ADDR_CTRL, 32'h0, r);
  endtask : test_call

  initial begin
    error_cnt = 0;
    cmp_count = 0;
    cyc = 0;
    port_cnt = 0;
    rst_n_i = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    test_regs();
    test_prog();
    test_call();
    give_verdict();
  end
endmodule : mid_core_test
